// ### loc_pkg.sv
// Lead-off control register: constants, field layout and carrier types.
// Assumes the serial port front end has already split each frame into
// read/write flag, 7-bit address and 24-bit data.
package loc_pkg;

  localparam int          LOC_DATA_W     = 24;
  localparam int          LOC_ADDR_W     = 7;
  localparam int          LOC_NUM_ELEC   = 6;
  localparam logic [6:0]  LOC_ADDR       = 7'h02;
  localparam logic [23:0] LOC_RESET_VAL  = 24'h000000;

  // Field positions within the 24-bit data word
  localparam int LOC_PHASE_LSB  = 18;
  localparam int LOC_ACEN_LSB   = 12;
  localparam int LOC_ACLVL_LSB  = 7;
  localparam int LOC_DCLVL_LSB  = 2;
  localparam int LOC_GLOBAL_AC_SELECT_BIT  = 1;
  localparam int LOC_MASTER_BIT = 0;

  // Electrode index inside the 6-bit vectors: LA=5, LL=4, RA=3, V1=2, V2=1, CE=0
  localparam int LOC_CE_IDX = 0;

  localparam logic [2:0] LOC_DC_OFF = 3'h0;

  typedef struct packed {
    logic [5:0] phase;
    logic [5:0] acEn;
    logic [1:0] acLevel;
    logic [2:0] dcLevel;
    logic       globalAcSelect;
    logic       masterEnable;
  } loc_ctl_t;

  typedef struct packed {
    logic [5:0] acDetectEn;
    logic [5:0] phaseInvert;
    logic [1:0] acLevel;
    logic [2:0] dc_excitation_level;
    logic       dcDetectEn;
  } loc_drive_t;

  typedef struct packed {
    loc_ctl_t    ctl;
    loc_drive_t  drive;
    logic [23:0] rdData;
    logic        rdValid;
  } loc_state_t;

endpackage : loc_pkg

// ### loc_lead_off_ctl.sv
// Lead-off control register and the enable/current decode that it drives.
// Assumes requests come from the serial port decoder, one per cycle at most,
// synchronous to clk; softReset is the decoded software reset pulse.
// calDacEnable is a level from the calibration DAC control, also on clk.
//
// How it works
// [R1] Bits 23:18 invert each electrode's ac phase
// [R2] Bits 17:12 enable ac lead-off per electrode
// [R3] Limb and chest ac enable ORs global select
// [R4] Global select never enables common electrode
// [R5] Bits 8:7 pick ac excitation level
// [R6] Bits 4:2 pick dc current, 10 nA steps
// [R7] Dc current only applies when select clear
// [R8] Bit 1 picks dc or ac detection
// [R9] Select ignored while master enable clear
// [R10] Bit 0 is the master lead-off enable
// [R11] Calibration DAC on forces ac detection off
// [R12] All fields clear after reset
// [R13] Reserved bits read zero, writes ignored
// [R14] Software reset restores the reset value
`timescale 1ns/1ps
module loc_lead_off_ctl (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [6:0]  regAddr,
  input  wire logic [23:0] regWrData,
  input  wire logic        softReset,
  input  wire logic        calDacEnable,
  output logic [23:0]      rdData,
  output logic             rdValid,
  output logic [5:0]       acDetectEn,
  output logic [5:0]       phaseInvert,
  output logic [1:0]       acLevel,
  output logic [2:0]       dc_excitation_level,
  output logic             dcDetectEn
);

  loc_pkg::loc_state_t state_r;
  loc_pkg::loc_state_t state_nxt;

  function automatic logic [23:0] pack_ctl(input loc_pkg::loc_ctl_t c);
    logic [23:0] w;
    w = loc_pkg::LOC_RESET_VAL;                                     // [R13]
    w[loc_pkg::LOC_PHASE_LSB +: 6]  = c.phase;
    w[loc_pkg::LOC_ACEN_LSB +: 6]   = c.acEn;
    w[loc_pkg::LOC_ACLVL_LSB +: 2]  = c.acLevel;
    w[loc_pkg::LOC_DCLVL_LSB +: 3]  = c.dcLevel;
    w[loc_pkg::LOC_GLOBAL_AC_SELECT_BIT]       = c.globalAcSelect;
    w[loc_pkg::LOC_MASTER_BIT]      = c.masterEnable;
    return w;
  endfunction : pack_ctl

  logic hit;
  assign hit = (regAddr == loc_pkg::LOC_ADDR);

  always_comb begin
    loc_pkg::loc_ctl_t c;
    logic              acAllowed;
    state_nxt = state_r;
    c = state_r.ctl;
    acAllowed = state_r.ctl.masterEnable && !calDacEnable;          // [R10] [R11]
    if (softReset) begin
      c = loc_pkg::loc_ctl_t'(19'h00000);                           // [R14]
    end else if (regWrite && hit) begin
      c.phase          = regWrData[loc_pkg::LOC_PHASE_LSB +: 6];    // [R1]
      c.acEn           = regWrData[loc_pkg::LOC_ACEN_LSB +: 6];     // [R2]
      c.acLevel        = regWrData[loc_pkg::LOC_ACLVL_LSB +: 2];    // [R5]
      c.dcLevel        = regWrData[loc_pkg::LOC_DCLVL_LSB +: 3];    // [R6]
      c.globalAcSelect = regWrData[loc_pkg::LOC_GLOBAL_AC_SELECT_BIT];         // [R8]
      c.masterEnable   = regWrData[loc_pkg::LOC_MASTER_BIT];        // [R10]
    end
    state_nxt.ctl = c;
    // Read returns the value held before any write in the same cycle
    state_nxt.rdValid = regRead;
    state_nxt.rdData  = (regRead && hit) ? pack_ctl(state_r.ctl) : 24'h000000;
    // Decode from the committed fields, so outputs trail a write by two cycles
    for (int i = 0; i < loc_pkg::LOC_NUM_ELEC; i++) begin
      if (i == loc_pkg::LOC_CE_IDX) begin
        state_nxt.drive.acDetectEn[i] = acAllowed && state_r.ctl.acEn[i];    // [R4]
      end else begin
        state_nxt.drive.acDetectEn[i] = acAllowed &&
          (state_r.ctl.acEn[i] || state_r.ctl.globalAcSelect);      // [R3] [R9]
      end
    end
    state_nxt.drive.phaseInvert = state_r.ctl.phase;                // [R1]
    state_nxt.drive.acLevel     = state_r.ctl.acLevel;              // [R5]
    state_nxt.drive.dcDetectEn  = state_r.ctl.masterEnable &&
                                  !state_r.ctl.globalAcSelect;      // [R8]
    state_nxt.drive.dc_excitation_level   = state_nxt.drive.dcDetectEn ?
                                  state_r.ctl.dcLevel : loc_pkg::LOC_DC_OFF;  // [R7]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0;                                                // [R12]
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdData      = state_r.rdData;
  assign rdValid     = state_r.rdValid;
  assign acDetectEn  = state_r.drive.acDetectEn;
  assign phaseInvert = state_r.drive.phaseInvert;
  assign acLevel     = state_r.drive.acLevel;
  assign dc_excitation_level   = state_r.drive.dc_excitation_level;
  assign dcDetectEn  = state_r.drive.dcDetectEn;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Write followed by read echoes data with reserved bits zero
  write_echo_a: assert property (                                   // [R13]
    regWrite && hit && !softReset ##1 regRead && hit && !regWrite && !softReset
    |=> rdData == ($past(regWrData, 2) & 24'hfff19f))
    else $error("read back differs from written value");
  soft_reset_a: assert property (                                   // [R14]
    softReset ##1 regRead && hit && !regWrite |=> rdData == loc_pkg::LOC_RESET_VAL)
    else $error("software reset did not clear register");
  ce_global_a: assert property (                                    // [R4]
    !state_r.ctl.acEn[loc_pkg::LOC_CE_IDX] |=> !acDetectEn[loc_pkg::LOC_CE_IDX])
    else $error("common electrode enabled by global select");
  global_or_a: assert property (                                    // [R3]
    state_r.ctl.masterEnable && state_r.ctl.globalAcSelect && !calDacEnable
    |=> acDetectEn[5:1] == 5'h1f)
    else $error("global select did not enable limb electrodes");
  cal_dac_a: assert property (                                      // [R11]
    calDacEnable |=> acDetectEn == 6'h00)
    else $error("ac detection active with calibration DAC on");
  master_off_a: assert property (                                   // [R9]
    !state_r.ctl.masterEnable |=> acDetectEn == 6'h00 && !dcDetectEn)
    else $error("detection active with master enable clear");
  dc_gate_a: assert property (                                      // [R7]
    state_r.ctl.globalAcSelect |=> dc_excitation_level == loc_pkg::LOC_DC_OFF && !dcDetectEn)
    else $error("dc current applied while ac selected");
  dc_level_a: assert property (                                     // [R6]
    regWrite && hit && !softReset && regWrData[1:0] == 2'h1
    ##1 !regWrite && !softReset |=> dc_excitation_level == $past(regWrData[4:2], 2))
    else $error("dc current does not follow written code");
  phase_follow_a: assert property (                                 // [R1]
    regWrite && hit && !softReset ##1 !softReset
    |=> phaseInvert == $past(regWrData[23:18], 2))
    else $error("phase outputs do not follow register");
  ac_level_a: assert property (                                     // [R5]
    regWrite && hit && !softReset ##1 !softReset
    |=> acLevel == $past(regWrData[8:7], 2))
    else $error("ac level does not follow register");

  // Storage: what a write or a software reset leaves in the register
  write_store_a: assert property (                                  // [R13]
    regWrite && hit && !softReset
    |=> pack_ctl(state_r.ctl) == ($past(regWrData) & 24'hfff19f))
    else $error("stored word differs from written value");
  write_land_a: assert property (                                   // [R2]
    regWrite && hit && !softReset
    |=> state_r.ctl.acEn == $past(regWrData[17:12]))
    else $error("ac enable bits not stored on write");
  soft_clear_a: assert property (                                   // [R14]
    softReset |=> state_r.ctl == '0)
    else $error("software reset left fields set");
  reserved_zero_a: assert property (                                // [R13]
    rdValid |-> rdData[11:9] == 3'h0 && rdData[6:5] == 2'h0)
    else $error("reserved bits read back nonzero");

  // Decode: outputs follow the fields committed one edge earlier
  ac_individual_a: assert property (                                // [R2]
    state_r.ctl.masterEnable && !state_r.ctl.globalAcSelect && !calDacEnable
    |=> acDetectEn == $past(state_r.ctl.acEn))
    else $error("ac enables do not follow individual bits");
  ac_off_a: assert property (                                       // [R2]
    !state_r.ctl.globalAcSelect && state_r.ctl.acEn == 6'h00
    |=> acDetectEn == 6'h00)
    else $error("ac enable active with all bits clear");
  ce_individual_a: assert property (                                // [R4]
    state_r.ctl.masterEnable && !calDacEnable && state_r.ctl.acEn[loc_pkg::LOC_CE_IDX]
    |=> acDetectEn[loc_pkg::LOC_CE_IDX])
    else $error("common electrode enable bit ignored");
  global_ce_a: assert property (                                    // [R4]
    state_r.ctl.globalAcSelect && !state_r.ctl.acEn[loc_pkg::LOC_CE_IDX]
    |=> !acDetectEn[loc_pkg::LOC_CE_IDX])
    else $error("global select reached common electrode");
  master_on_a: assert property (                                    // [R10]
    state_r.ctl.masterEnable && !calDacEnable && state_r.ctl.acEn != 6'h00
    |=> acDetectEn != 6'h00)
    else $error("master enable set but ac enables all off");
  sel_ignored_a: assert property (                                  // [R9]
    !state_r.ctl.masterEnable |=> dc_excitation_level == loc_pkg::LOC_DC_OFF)
    else $error("dc current applied with master enable clear");
  dc_select_a: assert property (                                    // [R8]
    state_r.ctl.masterEnable && !state_r.ctl.globalAcSelect |=> dcDetectEn)
    else $error("dc detection off with ac select clear");
  dc_follow_a: assert property (                                    // [R6]
    state_r.ctl.masterEnable && !state_r.ctl.globalAcSelect
    |=> dc_excitation_level == $past(state_r.ctl.dcLevel))
    else $error("dc current differs from stored code");
  dc_zero_a: assert property (                                      // [R6]
    state_r.ctl.dcLevel == loc_pkg::LOC_DC_OFF |=> dc_excitation_level == loc_pkg::LOC_DC_OFF)
    else $error("dc current nonzero for code zero");
  phase_pass_a: assert property (                                   // [R1]
    1'b1 |=> phaseInvert == $past(state_r.ctl.phase))
    else $error("phase outputs differ from stored bits");
  level_pass_a: assert property (                                   // [R5]
    1'b1 |=> acLevel == $past(state_r.ctl.acLevel))
    else $error("ac level differs from stored code");

  // One check per limb and chest electrode; CE is index 0 and left out
  for (genvar e = 1; e < loc_pkg::LOC_NUM_ELEC; e++) begin : g_limb_chk
    limb_enable_a: assert property (                                // [R3]
      state_r.ctl.masterEnable && !calDacEnable && state_r.ctl.acEn[e]
      |=> acDetectEn[e])
      else $error("electrode enable bit ignored");
  end

  cov_ac_global_c: cover property (dcDetectEn ##[1:20] acDetectEn[5:1] == 5'h1f);
  cov_ce_only_c:   cover property (acDetectEn == 6'h01);
  cov_soft_rst_c:  cover property (state_r.ctl.masterEnable ##1 softReset);
  cov_readback_c:  cover property (rdValid && rdData != 24'h000000);
  cov_write_read_c: cover property (regWrite && hit ##1 regRead && hit);

endmodule : loc_lead_off_ctl

// ### loc_lead_off_ctl_bench.sv
// Self-checking bench for the lead-off control register and its decode.
// Assumes outputs follow a write two edges later and rdValid right after the read edge.
`timescale 1ns/1ps
module loc_lead_off_ctl_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [6:0]  regAddr = 7'h00;
  logic [23:0] regWrData = 24'h000000;
  logic        softReset = 1'b0;
  logic        calDacEnable = 1'b0;
  logic [23:0] rdData;
  logic        rdValid;
  logic [5:0]  acDetectEn;
  logic [5:0]  phaseInvert;
  logic [1:0]  acLevel;
  logic [2:0]  dc_excitation_level;
  logic        dcDetectEn;
  logic [23:0] shadow;
  logic [31:0] rnd;
  logic [23:0] word;
  logic [23:0] corner [5] = '{24'h000003, 24'h000001, 24'h000002, 24'h03f01d, 24'hffffff};
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed = 11;

  always #4 clk = ~clk;

  loc_lead_off_ctl dut (.clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .softReset(softReset),
    .calDacEnable(calDacEnable), .rdData(rdData), .rdValid(rdValid),
    .acDetectEn(acDetectEn), .phaseInvert(phaseInvert), .acLevel(acLevel),
    .dc_excitation_level(dc_excitation_level), .dcDetectEn(dcDetectEn));

  // Packed as {acDetectEn, phaseInvert, acLevel, dc_excitation_level, dcDetectEn}
  function automatic logic [17:0] exp_decode(input logic [23:0] r, input logic cal);
    logic       on;
    logic [5:0] ac;
    on = r[0];
    ac = (on && !cal) ? (r[17:12] | {{5{r[1]}}, 1'b0}) : 6'h00;
    return {ac, r[23:18], r[8:7], (on && !r[1]) ? r[4:2] : 3'h0, on & ~r[1]};
  endfunction : exp_decode

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (exp !== got) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic access(input logic wr, input logic [6:0] a, input logic [23:0] d);
    @(posedge clk);
    #1;
    regWrite = wr;
    regRead = ~wr;
    regAddr = a;
    regWrData = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask : access

  // Compares the answer of a read taken at the last edge
  task automatic check_all;
    logic [23:0] exp;
    logic [23:0] got;
    exp = {6'h00, exp_decode(shadow, calDacEnable)};
    got = {6'h00, acDetectEn, phaseInvert, acLevel, dc_excitation_level, dcDetectEn};
    chk("rdValid", 24'h000001, {23'h000000, rdValid});
    chk("rdData", shadow & 24'hfff19f, rdData);
    chk("decode", exp, got);
  endtask : check_all

  // Read back, then compare decode once the write has had two edges
  task automatic verify;
    access(1'b0, 7'h02, 24'h000000);
    check_all();
  endtask : verify

  // Write, then read on the very next edge; the read must see the new word
  task automatic write_read(input logic [23:0] d);
    @(posedge clk);
    #1;
    regWrite = 1'b1;
    regRead = 1'b0;
    regAddr = 7'h02;
    regWrData = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    shadow = d;
    check_all();
  endtask : write_read

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    shadow = 24'h000000;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    verify();
    $display("reset test done");
    // Corners first, with random cal levels from the last corner on, then random words and stray addresses
    for (int i = 0; i < 45; i++) begin
      rnd = $random(seed);
      calDacEnable = (i >= 4) ? rnd[0] : 1'b0;
      regAddr = (i >= 5 && rnd[1]) ? 7'h03 : 7'h02;
      rnd = $random(seed);
      word = (i < 5) ? corner[i] : rnd[23:0];
      if (regAddr == 7'h02 && (i == 3 || rnd[24])) begin
        write_read(word);
      end else begin
        access(1'b1, regAddr, word);
        if (regAddr == 7'h02)
          shadow = word;
        verify();
      end
    end
    $display("random test done");
    // Soft reset must win over a write in the same cycle; read straight after
    write_read(24'hffffff);
    @(posedge clk);
    #1;
    softReset = 1'b1;
    regWrite = 1'b1;
    regAddr = 7'h02;
    regWrData = 24'hffffff;
    @(posedge clk);
    #1;
    softReset = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    shadow = 24'h000000;
    check_all();
    $display("soft reset test done");
    // Reset in mid-run from a loaded register
    write_read(24'h03f01d);
    rst_b = 1'b0;
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    shadow = 24'h000000;
    verify();
    $display("mid-run reset test done");
    stop_test();
  end
endmodule : loc_lead_off_ctl_bench
